/* File: shared/fprs_cfg.svh */
/*
 * Constants of the fan drive ramp smoothing block: register offsets,
 * reset values, full-scale times and ramp timing counts.
 * Assumes a 40 MHz core clock and 8-bit duty codes (0x00 = 0%, 0xFF = 100%).
 */
// Summary of operation
// - remote-1 rate field [2:0] of first register limits output change rate
// - slow clock select 0: codes give steps 1..48, full scale 37.5 s..0.8 s
// - slow clock select 1: same codes give full scale 52.2 s down to 1.1 s
// - per-output slow-down bit makes that output ramp four times slower
// - first register bit 3 enables remote-1 smoothing; 0 means no smoothing
// - bit 4 syncs speed inputs two to four to output three, else three, four
// - auto mode below low threshold: output one at 0% or minimum per bit 5
// - auto mode below low threshold: output two at 0% or minimum per bit 6
// - auto mode below low threshold: output three at 0% or minimum per bit 7
// - lock bit set makes both registers read-only; writes change nothing
// - local rate field [2:0] of second register, same code encoding
// - second register bit 3 enables local channel smoothing
// - remote-2 rate field [6:4] of second register limits change rate
// - second register bit 7 enables remote-2 channel smoothing
// - second register resets to all zeros
// - first register sits at 0x62 and resets to all zeros
`ifndef FPRS_CFG_SVH
`define FPRS_CFG_SVH

`define FPRS_ADDR_ACOU1 8'h62
`define FPRS_ADDR_RAMP_TWO 8'h63
`define FPRS_ACOU1_RST 8'h00
`define FPRS_RAMP_TWO_RST 8'h00
`define FPRS_DUTY_RST 8'h00
`define FPRS_DUTY_OFF 8'h00

// full scale 0% to 100% times at step size one, in milliseconds
`define FPRS_FULL_FAST_MS 64'd37500
`define FPRS_FULL_SLOW_MS 64'd52200
`define FPRS_CLK_KHZ 64'd40000
`define FPRS_FULL_SCALE 64'd255
// cycles between ramp ticks, longest time so rounded down
`define FPRS_FAST_TICK_CYC ((`FPRS_FULL_FAST_MS*`FPRS_CLK_KHZ)/`FPRS_FULL_SCALE)
`define FPRS_SLOW_TICK_CYC ((`FPRS_FULL_SLOW_MS*`FPRS_CLK_KHZ)/`FPRS_FULL_SCALE)
`define FPRS_SLOWDOWN_LAST 2'h3

`endif

/* File: shared/fprs_pkg.sv */
/*
 * Types of the fan drive ramp smoothing block.
 * Assumes fprs_cfg.svh supplies the numeric constants.
 */
`default_nettype none
package fprs_pkg;
	// temperature channel that steers one drive output
	typedef enum logic [1:0] {
		FPRS_CH_REMOTE1 = 2'b00,
		FPRS_CH_LOCAL = 2'b01,
		FPRS_CH_REMOTE2 = 2'b10
	} fprs_ch_sel_t;

	// first acoustics register layout, msb first
	typedef struct packed {
		logic out3_floor_select;
		logic out2_floor_select;
		logic out1_floor_select;
		logic tach_sync_all;
		logic remote1_smooth_on;
		logic [2:0] remote1_ramp_rate;
	} fprs_acou1_t;

	// second acoustics register layout, msb first
	typedef struct packed {
		logic remote2_smooth_on;
		logic [2:0] remote2_ramp_rate;
		logic local_smooth_on;
		logic [2:0] local_ramp_rate;
	} fprs_ramp_two_t;

	// per-output request from the automatic control loop
	typedef struct packed {
		fprs_ch_sel_t ch_sel;
		logic [7:0] target;
		logic [7:0] floor_duty;
	} fprs_out_ctl_t;
endpackage
`default_nettype wire

/* File: hdl/fprs_ramp_unit.sv */
/*
 * One slew-limited duty register: follows its target directly when
 * smoothing is off, else moves at most one step per tick.
 * Assumes tick_i is a one-cycle pulse on core_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fprs_cfg.svh"
module fprs_ramp_unit (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic smooth_on_i,
	input wire logic [5:0] step_i,
	input wire logic [7:0] target_i,
	output logic [7:0] duty_o
);
	logic [7:0] duty_reg;
	logic [7:0] duty_next;
	logic [7:0] gap;
	logic rising;

	// distance to target and direction of travel
	assign rising = target_i > duty_reg;
	assign gap = rising ? target_i - duty_reg : duty_reg - target_i;

	// clamp to target on the last step so there is no overshoot
	always_comb begin
		duty_next = duty_reg;
		if (!smooth_on_i) begin
			duty_next = target_i;
		end else if (tick_i && gap != 8'h00) begin
			if (gap > {2'b00, step_i}) begin
				duty_next = rising ? duty_reg + {2'b00, step_i}
					: duty_reg - {2'b00, step_i};
			end else begin
				duty_next = target_i;
			end
		end
	end

	// duty register
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			duty_reg <= `FPRS_DUTY_RST;
		end else begin
			duty_reg <= duty_next;
		end
	end

	assign duty_o = duty_reg;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	ramp_step_a: assert property (
		(smooth_on_i && tick_i && gap > {2'b00, step_i}) |=>
		(duty_reg == ($past(rising) ? 8'($past(duty_reg) + $past(step_i))
			: 8'($past(duty_reg) - $past(step_i)))))
		else $error("ramp step size wrong");
	ramp_land_a: assert property (
		(smooth_on_i && tick_i && gap <= {2'b00, step_i}) |=>
		(duty_reg == $past(target_i)))
		else $error("ramp did not land on target");
	ramp_hold_a: assert property (
		(smooth_on_i && !tick_i) |=> $stable(duty_reg))
		else $error("duty moved between ticks");
	no_smooth_a: assert property (
		!smooth_on_i |=> duty_reg == $past(target_i))
		else $error("unsmoothed output did not follow target");
	ramp_done_c: cover property (
		smooth_on_i && tick_i && gap != 8'h00 && gap <= {2'b00, step_i});
endmodule
`default_nettype wire

/* File: hdl/fprs_top.sv */
/*
 * Fan drive ramp smoothing: the two acoustics registers, the ramp tick
 * generator, the floor selection below the low threshold and one slew
 * limited duty register per drive output.
 * Assumes the register port, lock, mode and control inputs all come from
 * logic on core_clk_i, so none of them is synchronised here. The lower
 * pulse generator consumes the three duty codes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fprs_cfg.svh"
module fprs_top #(
	parameter int unsigned FAST_TICK_CYC = int'(`FPRS_FAST_TICK_CYC),
	parameter int unsigned SLOW_TICK_CYC = int'(`FPRS_SLOW_TICK_CYC)
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic lock_i,
	input wire logic slow_clk_sel_i,
	input wire logic [2:0] slow_down_i,
	input wire logic auto_mode_i,
	input wire logic [2:0] below_low_i,
	input wire fprs_pkg::fprs_out_ctl_t [2:0] out_ctl_i,
	output logic [7:0] fan_drive_one_o,
	output logic [7:0] fan_drive_two_o,
	output logic [7:0] fan_drive_three_o,
	output logic [2:0] tach_sync_o
);
	localparam logic [23:0] FAST_LAST = 24'(FAST_TICK_CYC - 1);
	localparam logic [23:0] SLOW_LAST = 24'(SLOW_TICK_CYC - 1);

	fprs_pkg::fprs_acou1_t acou1_reg;
	fprs_pkg::fprs_ramp_two_t ramp_two_reg;
	logic [7:0] rdata_reg;
	logic [2:0] tach_sync_reg;
	logic [23:0] base_cnt_reg;
	logic [23:0] base_last;
	logic base_tick;
	logic [1:0] quarter_reg [3];
	logic [2:0] out_tick;
	logic [2:0] out_rate [3];
	logic [2:0] out_smooth;
	logic [5:0] out_step [3];
	logic [7:0] out_target [3];
	logic [7:0] duty [3];
	logic wr_acou1;
	logic wr_ramp_two;

	// code to step size, shared by all three channels
	function automatic logic [5:0] rate_step(input logic [2:0] code);
		logic [5:0] step;
		step = 6'h01;
		unique case (code)
			3'h0: step = 6'h01;
			3'h1: step = 6'h02;
			3'h2: step = 6'h03;
			3'h3: step = 6'h04;
			3'h4: step = 6'h08;
			3'h5: step = 6'h0c;
			3'h6: step = 6'h18;
			3'h7: step = 6'h30;
		endcase
		return step;
	endfunction

	// write strobes, dead once the lock bit is set
	assign wr_acou1 = reg_wr_i && !lock_i &&
		reg_addr_i == `FPRS_ADDR_ACOU1;
	assign wr_ramp_two = reg_wr_i && !lock_i &&
		reg_addr_i == `FPRS_ADDR_RAMP_TWO;

	// first acoustics register
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			acou1_reg <= `FPRS_ACOU1_RST;
		end else if (wr_acou1) begin
			acou1_reg <= reg_wdata_i;
		end
	end

	// second acoustics register
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ramp_two_reg <= `FPRS_RAMP_TWO_RST;
		end else if (wr_ramp_two) begin
			ramp_two_reg <= reg_wdata_i;
		end
	end

	// readback, held until the next read; unmapped offsets read zero
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd_i) begin
			if (reg_addr_i == `FPRS_ADDR_ACOU1) begin
				rdata_reg <= acou1_reg;
			end else if (reg_addr_i == `FPRS_ADDR_RAMP_TWO) begin
				rdata_reg <= ramp_two_reg;
			end else begin
				rdata_reg <= 8'h00;
			end
		end
	end

	// speed inputs three and four tied to output three; input two only while bit 4 is set
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tach_sync_reg <= 3'b110;
		end else begin
			tach_sync_reg <= {2'b11, acou1_reg.tach_sync_all};
		end
	end

	// tick period; slow select stretches every rate by the same ratio
	assign base_last = slow_clk_sel_i ? SLOW_LAST : FAST_LAST;
	// >= guards against a stuck count when the period shrinks
	assign base_tick = base_cnt_reg >= base_last;

	// base prescaler, one tick per full-scale/255 interval
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			base_cnt_reg <= 24'h00_0000;
		end else if (base_tick) begin
			base_cnt_reg <= 24'h00_0000;
		end else begin
			base_cnt_reg <= base_cnt_reg + 24'h00_0001;
		end
	end

	// per output quarter counters and control selection
	for (genvar k = 0; k < 3; k++) begin : g_out
		// slow-down passes only every fourth base tick
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				quarter_reg[k] <= 2'h0;
			end else if (base_tick) begin
				quarter_reg[k] <= quarter_reg[k] + 2'h1;
			end
		end
		assign out_tick[k] = base_tick && (!slow_down_i[k] ||
			quarter_reg[k] == `FPRS_SLOWDOWN_LAST);

		// rate and enable follow the channel that owns this output
		always_comb begin
			out_rate[k] = acou1_reg.remote1_ramp_rate;
			out_smooth[k] = acou1_reg.remote1_smooth_on;
			unique case (out_ctl_i[k].ch_sel)
				fprs_pkg::FPRS_CH_REMOTE1: begin
					out_rate[k] = acou1_reg.remote1_ramp_rate;
					out_smooth[k] = acou1_reg.remote1_smooth_on;
				end
				fprs_pkg::FPRS_CH_LOCAL: begin
					out_rate[k] = ramp_two_reg.local_ramp_rate;
					out_smooth[k] = ramp_two_reg.local_smooth_on;
				end
				fprs_pkg::FPRS_CH_REMOTE2: begin
					out_rate[k] = ramp_two_reg.remote2_ramp_rate;
					out_smooth[k] = ramp_two_reg.remote2_smooth_on;
				end
				default: begin
					// unused code: treat as unsmoothed
					out_smooth[k] = 1'b0;
				end
			endcase
		end
		assign out_step[k] = rate_step(out_rate[k]);
	end

	// below threshold minus hysteresis: off or floor per select bit
	assign out_target[0] = (auto_mode_i && below_low_i[0]) ?
		(acou1_reg.out1_floor_select ? out_ctl_i[0].floor_duty
		: `FPRS_DUTY_OFF) : out_ctl_i[0].target;
	assign out_target[1] = (auto_mode_i && below_low_i[1]) ?
		(acou1_reg.out2_floor_select ? out_ctl_i[1].floor_duty
		: `FPRS_DUTY_OFF) : out_ctl_i[1].target;
	assign out_target[2] = (auto_mode_i && below_low_i[2]) ?
		(acou1_reg.out3_floor_select ? out_ctl_i[2].floor_duty
		: `FPRS_DUTY_OFF) : out_ctl_i[2].target;

	// slew limited duty registers
	for (genvar k = 0; k < 3; k++) begin : g_ramp
		fprs_ramp_unit u_ramp (
			.core_clk_i(core_clk_i),
			.rst_i(rst_i),
			.tick_i(out_tick[k]),
			.smooth_on_i(out_smooth[k]),
			.step_i(out_step[k]),
			.target_i(out_target[k]),
			.duty_o(duty[k])
		);
	end

	// outputs, each from a flip-flop
	assign fan_drive_one_o = duty[0];
	assign fan_drive_two_o = duty[1];
	assign fan_drive_three_o = duty[2];
	assign reg_rdata_o = rdata_reg;
	assign tach_sync_o = tach_sync_reg;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	reset_value_a: assert property (
		$past(rst_i) |-> (acou1_reg == `FPRS_ACOU1_RST &&
		ramp_two_reg == `FPRS_RAMP_TWO_RST))
		else $error("acoustics registers not zero after reset");
	locked_write_a: assert property (
		(reg_wr_i && lock_i) |=> ($stable(acou1_reg) && $stable(ramp_two_reg)))
		else $error("write changed a locked register");
	acou1_write_a: assert property (
		(reg_wr_i && !lock_i && reg_addr_i == 8'h62) |=>
		(acou1_reg == $past(reg_wdata_i)))
		else $error("write at 0x62 not stored");
	local_ramp_rate_write_a: assert property (
		(reg_wr_i && !lock_i && reg_addr_i == 8'h63) |=>
		(ramp_two_reg == $past(reg_wdata_i)))
		else $error("write at 0x63 not stored");
	sync_mask_a: assert property (
		##1 (tach_sync_o == {2'b11, $past(acou1_reg[4])}))
		else $error("speed input sync mask wrong");
	tick_fast_a: assert property (
		(base_tick && !slow_clk_sel_i && $stable(slow_clk_sel_i)) |->
		base_cnt_reg == FAST_LAST)
		else $error("fast tick period wrong");
	tick_slow_a: assert property (
		(base_tick && slow_clk_sel_i && $stable(slow_clk_sel_i)) |->
		base_cnt_reg == SLOW_LAST)
		else $error("slow tick period wrong");
	quarter_tick_a: assert property (
		(slow_down_i[0] && out_tick[0]) |-> (base_tick &&
		quarter_reg[0] == 2'h3))
		else $error("slowed output ticked too often");
	step_code_a: assert property (
		(out_ctl_i[0].ch_sel == fprs_pkg::FPRS_CH_REMOTE1 &&
		acou1_reg.remote1_ramp_rate == 3'h7) |-> out_step[0] == 6'h30)
		else $error("top rate code not step 48");
	floor_one_a: assert property (
		(auto_mode_i && below_low_i[0] && !acou1_reg.out1_floor_select &&
		!out_smooth[0]) |=> fan_drive_one_o == 8'h00)
		else $error("output one not off below threshold");
	floor_three_a: assert property (
		(auto_mode_i && below_low_i[2] && acou1_reg.out3_floor_select &&
		!out_smooth[2]) |=> fan_drive_three_o == $past(out_ctl_i[2].floor_duty))
		else $error("output three not at floor below threshold");
	locked_try_c: cover property (reg_wr_i && lock_i);
	slow_tick_c: cover property (out_tick[1] && slow_down_i[1]);
	floor_c: cover property (auto_mode_i && below_low_i[1] &&
		acou1_reg.out2_floor_select);
endmodule
`default_nettype wire

/* File: verif/fprs_fan_model.sv */
/*
 * fan model: three fans whose speed lags their duty code, plus a count
 * of the speed inputs that are measured against drive three.
 * assumes duty codes and sync flags on core_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module fprs_fan_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [2:0][7:0] duty_i,
	input wire logic [2:0] tach_sync_i,
	output logic [2:0][7:0] speed_o,
	output logic [1:0] fans_on_three_o
);
	// rotor inertia: one code per clock toward the drive
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			speed_o <= '0;
		end else begin
			for (int k = 0; k < 3; k++) begin
				if (speed_o[k] < duty_i[k]) begin
					speed_o[k] <= speed_o[k] + 8'h01;
				end else if (speed_o[k] > duty_i[k]) begin
					speed_o[k] <= speed_o[k] - 8'h01;
				end
			end
		end
	end
	// fans sharing drive three, one per synchronised speed input
	assign fans_on_three_o = 2'(tach_sync_i[0]) + 2'(tach_sync_i[1])
		+ 2'(tach_sync_i[2]);
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
/*
 * testbench: register accesses, ramp step and tick spacing, floor
 * selection and lock, all checked against expected values.
 * assumes short tick counts of 20 and 28 cycles on a 40 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk, rst, wr_s, rd_s, lock, slow, auto_m;
	logic [7:0] addr, wdata, rdata, d1, d2, d3;
	logic [2:0] sd, below, ts;
	logic [1:0] fans;
	logic [2:0][7:0] dv, spd;
	logic [7:0] mdl [3];
	logic [7:0] steps [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
	fprs_pkg::fprs_out_ctl_t [2:0] ctl;
	int n_errors = 0;
	int compares = 0;
	assign dv = {d3, d2, d1};
	fprs_top #(.FAST_TICK_CYC(20), .SLOW_TICK_CYC(28)) dut (
		.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
		.reg_wr_i(wr_s), .reg_wdata_i(wdata), .reg_rd_i(rd_s),
		.reg_rdata_o(rdata), .lock_i(lock), .slow_clk_sel_i(slow),
		.slow_down_i(sd), .auto_mode_i(auto_m), .below_low_i(below),
		.out_ctl_i(ctl), .fan_drive_one_o(d1), .fan_drive_two_o(d2),
		.fan_drive_three_o(d3), .tach_sync_o(ts));
	fprs_fan_model fans_u (.core_clk_i(clk), .rst_i(rst), .duty_i(dv),
		.tach_sync_i(ts), .speed_o(spd), .fans_on_three_o(fans));
	// 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_s = 1'b1;
		@(negedge clk);
		wr_s = 1'b0;
	endtask
	// data is registered at the read edge
	task automatic rd(logic [7:0] a, logic [7:0] exp, string nm);
		@(negedge clk);
		addr = a;
		rd_s = 1'b1;
		@(negedge clk);
		rd_s = 1'b0;
		chk(nm, exp, rdata);
	endtask
	// unsmoothed path follows its target one edge later
	task automatic direct(int k, logic [7:0] t);
		@(negedge clk);
		ctl[k].target = t;
		@(negedge clk);
		chk("direct duty", t, dv[k]);
		mdl[k] = t;
	endtask
	// every change is one step, spaced by exactly one tick period
	task automatic ramp(int k, logic [7:0] stp, int per);
		logic [7:0] d, t, nx;
		int last;
		d = 8'(2 * stp + 1);
		t = (mdl[k] >= 8'h80) ? mdl[k] - d : mdl[k] + d;
		last = -1;
		@(negedge clk);
		ctl[k].target = t;
		for (int c = 0; c < 12 * per && mdl[k] != t; c++) begin
			@(negedge clk);
			if (dv[k] !== mdl[k]) begin
				if (t > mdl[k]) begin
					nx = (t - mdl[k] > stp) ? mdl[k] + stp : t;
				end else begin
					nx = (mdl[k] - t > stp) ? mdl[k] - stp : t;
				end
				chk("ramp step", nx, dv[k]);
				if (last >= 0) chk("tick gap", 8'(per), 8'(c - last));
				last = c;
				mdl[k] = nx;
			end
		end
		chk("ramp end", t, dv[k]);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// watchdog, well past the expected run of a few thousand cycles
	initial begin
		#(25 * 40000);
		n_errors++;
		$display("[ERR] watchdog expected finish seen hang");
		print_verdict();
	end
	initial begin
		{rst, wr_s, rd_s, lock, slow, auto_m} = 6'b100000;
		{addr, wdata, sd, below} = '0;
		ctl = '0;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		rd(8'h62, 8'h00, "reg one reset");
		rd(8'h63, 8'h00, "reg two reset");
		chk("sync reset", 8'h06, 8'(ts));
		wr(8'h62, 8'h10);
		@(negedge clk);
		chk("sync all", 8'h07, 8'(ts));
		chk("fans on three", 8'h03, 8'(fans));
		rd(8'h62, 8'h10, "reg one write");
		// nonzero readback first, so a bad decode shows as stale data
		rd(8'h70, 8'h00, "unmapped");
		$display("test registers done");
		for (int k = 0; k < 3; k++) begin
			ctl[k].ch_sel = fprs_pkg::fprs_ch_sel_t'(2'(k));
			direct(k, 8'(8'h5a + k));
		end
		$display("test smoothing off done");
		for (int c = 0; c < 8; c++) begin
			wr(8'h62, {5'b00011, 3'(c)});
			wr(8'h63, {1'b1, 3'(c), 1'b1, 3'(c)});
			for (int k = 0; k < 3; k++) ramp(k, steps[c], 20);
		end
		$display("test step table done");
		slow = 1'b1;
		ramp(0, 8'd48, 28);
		slow = 1'b0;
		sd = 3'b010;
		ramp(1, 8'd48, 80);
		sd = 3'b000;
		$display("test timebase done");
		for (int k = 0; k < 3; k++) begin
			ctl[k].ch_sel = fprs_pkg::fprs_ch_sel_t'(2'b11);
			ctl[k].floor_duty = 8'(8'h40 + k);
		end
		auto_m = 1'b1;
		below = 3'b111;
		for (int j = 0; j < 4; j++) begin
			wr(8'h62, 8'h20 << j);
			repeat (2) @(negedge clk);
			for (int k = 0; k < 3; k++) begin
				chk("floor", (k == j) ? 8'(8'h40 + k) : 8'h00, dv[k]);
			end
		end
		auto_m = 1'b0;
		repeat (2) @(negedge clk);
		for (int k = 0; k < 3; k++) chk("manual", mdl[k], dv[k]);
		$display("test floor done");
		lock = 1'b1;
		wr(8'h62, 8'h55);
		wr(8'h63, 8'h2a);
		rd(8'h62, 8'h00, "locked one");
		rd(8'h63, 8'hff, "locked two");
		lock = 1'b0;
		wr(8'h63, 8'h12);
		rd(8'h63, 8'h12, "unlocked two");
		$display("test lock done");
		print_verdict();
	end
endmodule
`default_nettype wire
